// ---- ssp_pkg.sv ----
// Package of constants and types for the second serial port
package ssp_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_MASK_OFS = 8'hBA;
   localparam logic [7:0] SER_CTRL_OFS = 8'hC0;
   localparam logic [7:0] SER_DATA_OFS = 8'hC1;
   localparam logic [7:0] STATION_ADDR_OFS = 8'hAA;
   localparam logic [7:0] POWER_CTRL_OFS = 8'hD0;
   localparam logic [7:0] TX_STATUS_OFS = 8'hD1;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'hD2;
   localparam logic [7:0] IRQ_MASK_OFS = 8'hD3;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTL_SM0 = 7;
   localparam int CTL_SM1 = 6;
   localparam int CTL_SM2 = 5;
   localparam int CTL_REN = 4;
   localparam int CTL_TB8 = 3;
   localparam int CTL_RB8 = 2;
   localparam int CTL_TI = 1;
   localparam int CTL_RI = 0;
   localparam int PWR_FESEL = 6;
   localparam int PWR_SMOD = 7;
   localparam int IRQ_TX = 0;
   localparam int IRQ_RX = 1;
   localparam int IRQ_FE = 2;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam logic [5:0] DIV12 = 6'h0B;
   localparam logic [5:0] DIV4 = 6'h03;
   localparam logic [5:0] DIV64 = 6'h3F;
   localparam logic [5:0] DIV32 = 6'h1F;
   localparam logic [3:0] OVF_PER_BIT = 4'h0F;
   localparam logic [3:0] SAMPLE_PT = 4'h07;
   localparam logic [3:0] BITS_M0 = 4'h8;
   localparam logic [3:0] BITS_M1 = 4'h9;
   localparam logic [3:0] BITS_M23 = 4'hA;

   typedef enum logic [3:0] {
      SSP_IDLE = 4'h1,
      SSP_START = 4'h2,
      SSP_DATA = 4'h4,
      SSP_STOP = 4'h8
   } ssp_st_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ssp_bus_t;
endpackage

// ---- ssp_baud.sv ----
// Bit tick generator: fixed dividers or timer overflow based
`timescale 1ns/1ns
module ssp_baud
   import ssp_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic [1:0] mode_in,
   input wire logic sm2_in,
   input wire logic smod_in,
   input wire logic ovf_in,
   input wire logic restart_in,
   output logic tick_out,
   output logic sample_out
);
   typedef struct packed {
      logic [5:0] div;
      logic [3:0] sub;
      logic tick;
      logic sample;
   } ssp_baud_t;
   ssp_baud_t s_reg, s_next;
   logic [5:0] lim;
   logic use_ovf;

   always_comb begin
      s_next = s_reg;
      s_next.tick = 1'b0;
      s_next.sample = 1'b0;
      use_ovf = mode_in[0] && (mode_in != 2'b00);
      unique case (mode_in)
         2'b00: lim = sm2_in ? DIV4 : DIV12;
         2'b10: lim = smod_in ? DIV32 : DIV64;
         default: lim = BYTE_ZERO[5:0];
      endcase
      if (restart_in) begin
         s_next.div = BYTE_ZERO[5:0];
         s_next.sub = 4'h0;
      end else if (use_ovf) begin
         if (ovf_in) begin
            s_next.sub = s_reg.sub + 4'h1;
            s_next.sample = (s_reg.sub == SAMPLE_PT);
            s_next.tick = (s_reg.sub == OVF_PER_BIT);
         end
      end else if (s_reg.div == lim) begin
         s_next.div = BYTE_ZERO[5:0];
         s_next.tick = 1'b1;
      end else begin
         s_next.div = s_reg.div + 6'h01;
         s_next.sample = (s_reg.div == (lim >> 1));
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
   assign tick_out = s_reg.tick;
   assign sample_out = s_reg.sample;
endmodule

// ---- ssp_core.sv ----
// Second serial port: registers, transmitter, receiver, interrupts
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
module ssp_core
   import ssp_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic timer_ovf_in,
   input wire logic rxd_in,
   output logic [7:0] rdata_out,
   output logic txd_out,
   output logic sclk_out,
   output logic rxd_oe_n_out,
   output logic irq_out
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic fe;
      logic [7:0] mask;
      logic [7:0] saddr;
      logic [7:0] pwr;
      logic [7:0] rxbuf;
      logic [7:0] rdata;
      logic [2:0] ists;
      logic [2:0] imsk;
      logic irq;
      ssp_st_t tst;
      logic [3:0] tcnt;
      logic [8:0] tsh;
      logic txd;
      logic tact;
      ssp_st_t rst;
      logic [3:0] rcnt;
      logic [8:0] rsh;
      logic sclk;
      logic oe_n;
      logic [1:0] rsync;
      logic rprev;
   } ssp_core_t;
   ssp_core_t s_reg, s_next;
   ssp_bus_t bus;
   logic tick, sample, restart;
   logic [1:0] mode;
   logic [7:0] ctrl_view;
   logic rxd_s, ti_set, ri_set, fe_set;
   logic [3:0] nbits;
   logic data_wr;

   function automatic logic addr_hit(input logic [7:0] a,
                                     input logic [7:0] sa,
                                     input logic [7:0] m);
      addr_hit = ((a & m) == (sa & m));
   endfunction

   // Last bit of a frame: the count reaches the data bits of the mode
   function automatic logic last_bit(input logic [3:0] cnt,
                                     input logic [3:0] nb,
                                     input logic m0);
      last_bit = (cnt + 4'h1 == nb - 4'h1 + {3'h0, m0});
   endfunction

   assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
   assign data_wr = bus.wr && (bus.addr == SER_DATA_OFS);
   assign rxd_s = s_reg.rsync[1];
   // Shared bit timer waits at zero while both halves are idle
   assign restart = (s_reg.tst == SSP_IDLE) && (s_reg.rst == SSP_IDLE);

   ssp_baud u_baud (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .mode_in(mode),
      .sm2_in(s_reg.ctrl[CTL_SM2]),
      .smod_in(s_reg.pwr[PWR_SMOD]),
      .ovf_in(timer_ovf_in),
      .restart_in(restart && !data_wr),
      .tick_out(tick),
      .sample_out(sample)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      ti_set = 1'b0;
      ri_set = 1'b0;
      fe_set = 1'b0;
      mode = {s_reg.ctrl[CTL_SM0], s_reg.ctrl[CTL_SM1]};
      nbits = (mode == 2'b00) ? BITS_M0 :
              (mode == 2'b01) ? BITS_M1 : BITS_M23;
      s_next.rsync = {s_reg.rsync[0], rxd_in};
      s_next.rprev = rxd_s;
      ctrl_view = s_reg.ctrl;
      if (s_reg.pwr[PWR_FESEL]) begin
         ctrl_view[CTL_SM0] = s_reg.fe;
      end

      // ---------------------------------------------------------
      // Transmitter
      // ---------------------------------------------------------
      unique case (s_reg.tst)
         SSP_IDLE: begin
            s_next.txd = 1'b1;
            s_next.sclk = 1'b1;
            if (data_wr) begin
               s_next.tsh = {s_reg.ctrl[CTL_TB8], bus.wdata};
               // Mode 1 frame has no ninth bit
               if (mode == 2'b01) begin
                  s_next.tsh[8] = 1'b1;
               end
               s_next.tcnt = 4'h0;
               s_next.tact = 1'b1;
               s_next.tst = (mode == 2'b00) ? SSP_DATA : SSP_START;
               s_next.oe_n = (mode != 2'b00);
            end
         end
         SSP_START: begin
            s_next.txd = 1'b0;
            if (tick) begin
               s_next.tst = SSP_DATA;
            end
         end
         SSP_DATA: begin
            s_next.txd = s_reg.tsh[0];
            if (mode == 2'b00) begin
               s_next.sclk = !sample && (s_reg.sclk || tick);
            end
            if (tick) begin
               s_next.tsh = {1'b1, s_reg.tsh[8:1]};
               s_next.tcnt = s_reg.tcnt + 4'h1;
               if (last_bit(s_reg.tcnt, nbits, mode == 2'b00)) begin
                  if (mode == 2'b00) begin
                     ti_set = 1'b1;
                     s_next.tst = SSP_IDLE;
                     s_next.oe_n = 1'b1;
                  end else begin
                     ti_set = 1'b1;
                     s_next.tst = SSP_STOP;
                  end
                  s_next.tact = 1'b0;
               end
            end
         end
         SSP_STOP: begin
            s_next.txd = 1'b1;
            if (tick) begin
               s_next.tst = SSP_IDLE;
            end
         end
      endcase

      // ---------------------------------------------------------
      // Receiver
      // ---------------------------------------------------------
      unique case (s_reg.rst)
         SSP_IDLE: begin
            s_next.rcnt = 4'h0;
            if (s_reg.ctrl[CTL_REN] && s_reg.tst == SSP_IDLE) begin
               if (mode == 2'b00 && !s_reg.ctrl[CTL_RI]) begin
                  s_next.rst = SSP_DATA;
               end else if (mode != 2'b00 && s_reg.rprev && !rxd_s) begin
                  s_next.rst = SSP_START;
               end
            end
         end
         SSP_START: begin
            if (sample && rxd_s) begin
               s_next.rst = SSP_IDLE;
            end else if (tick) begin
               s_next.rst = SSP_DATA;
            end
         end
         SSP_DATA: begin
            if (sample) begin
               s_next.rsh = {rxd_s, s_reg.rsh[8:1]};
               s_next.rcnt = s_reg.rcnt + 4'h1;
               if (last_bit(s_reg.rcnt, nbits, mode == 2'b00)) begin
                  s_next.rst = SSP_STOP;
               end
            end
         end
         SSP_STOP: begin
            if (mode == 2'b00) begin
               // Mode 0 has no stop bit: wait out the eighth bit time
               if (tick) begin
                  s_next.rst = SSP_IDLE;
                  s_next.rxbuf = s_reg.rsh[8:1];
                  ri_set = 1'b1;
               end
            end else if (sample) begin
               s_next.rst = SSP_IDLE;
               fe_set = !rxd_s;
               if (mode == 2'b01) begin
                  if (!(s_reg.ctrl[CTL_SM2] && !rxd_s)) begin
                     ri_set = 1'b1;
                     s_next.rxbuf = s_reg.rsh[8:1];
                     s_next.ctrl[CTL_RB8] = rxd_s;
                  end
               end else if (!s_reg.ctrl[CTL_SM2] || (s_reg.rsh[8] &&
                        addr_hit(s_reg.rsh[7:0], s_reg.saddr,
                                 s_reg.mask))) begin
                  ri_set = 1'b1;
                  s_next.rxbuf = s_reg.rsh[7:0];
                  s_next.ctrl[CTL_RB8] = s_reg.rsh[8];
               end
            end
         end
      endcase

      // ---------------------------------------------------------
      // Register writes; hardware set wins over clear
      // ---------------------------------------------------------
      if (bus.wr) begin
         unique case (bus.addr)
            SER_CTRL_OFS: begin
               s_next.ctrl = bus.wdata;
               if (s_reg.pwr[PWR_FESEL]) begin
                  s_next.ctrl[CTL_SM0] = s_reg.ctrl[CTL_SM0];
                  s_next.fe = bus.wdata[CTL_SM0];
               end
            end
            ADDR_MASK_OFS: s_next.mask = bus.wdata;
            STATION_ADDR_OFS: s_next.saddr = bus.wdata;
            POWER_CTRL_OFS: s_next.pwr = bus.wdata;
            IRQ_STATUS_OFS: s_next.ists = s_reg.ists & ~bus.wdata[2:0];
            IRQ_MASK_OFS: s_next.imsk = bus.wdata[2:0];
            default: ;
         endcase
      end
      if (ti_set) begin
         s_next.ctrl[CTL_TI] = 1'b1;
         s_next.ists[IRQ_TX] = 1'b1;
      end
      if (ri_set) begin
         s_next.ctrl[CTL_RI] = 1'b1;
         s_next.ists[IRQ_RX] = 1'b1;
      end
      if (fe_set) begin
         s_next.fe = 1'b1;
         s_next.ists[IRQ_FE] = 1'b1;
      end
      s_next.irq = |(s_next.ists & s_next.imsk);

      // ---------------------------------------------------------
      // Read data
      // ---------------------------------------------------------
      s_next.rdata = BYTE_ZERO;
      if (bus.rd) begin
         unique case (bus.addr)
            SER_CTRL_OFS: s_next.rdata = ctrl_view;
            SER_DATA_OFS: s_next.rdata = s_reg.rxbuf;
            ADDR_MASK_OFS: s_next.rdata = s_reg.mask;
            STATION_ADDR_OFS: s_next.rdata = s_reg.saddr;
            POWER_CTRL_OFS: s_next.rdata = s_reg.pwr;
            TX_STATUS_OFS: s_next.rdata = {7'h00, s_reg.tact};
            IRQ_STATUS_OFS: s_next.rdata = {5'h00, s_reg.ists};
            IRQ_MASK_OFS: s_next.rdata = {5'h00, s_reg.imsk};
            default: s_next.rdata = BYTE_ZERO;
         endcase
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         s_reg <= '0;
         s_reg.tst <= SSP_IDLE;
         s_reg.rst <= SSP_IDLE;
         s_reg.txd <= 1'b1;
         s_reg.sclk <= 1'b1;
         s_reg.oe_n <= 1'b1;
         s_reg.rsync <= 2'b11;
         s_reg.rprev <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rdata_out = s_reg.rdata;
   assign txd_out = s_reg.txd;
   assign sclk_out = s_reg.sclk;
   assign rxd_oe_n_out = s_reg.oe_n;
   assign irq_out = s_reg.irq;
endmodule

// ---- ssp_core_monitor.sv ----
// Bus and pin checker for the second serial port
`timescale 1ns/1ns
module ssp_core_monitor
   import ssp_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic timer_ovf_in,
   input wire logic rxd_in,
   input wire logic [7:0] rdata_out,
   input wire logic txd_out,
   input wire logic sclk_out,
   input wire logic rxd_oe_n_out,
   input wire logic irq_out
);
   // ------------------------------------------------------------
   // Mode and mask shadows
   // ------------------------------------------------------------
   logic [1:0] mode_reg;
   logic mzero_reg;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         mode_reg <= 2'h0;
         mzero_reg <= 1'b1;
      end else if (wr_in && addr_in == SER_CTRL_OFS) begin
         mode_reg <= wdata_in[7:6];
      end else if (wr_in && addr_in == IRQ_MASK_OFS) begin
         mzero_reg <= (wdata_in == BYTE_ZERO);
      end
   end
   chk_reset_outputs: assert property (disable iff (1'b0)
      rst_in |=> txd_out && sclk_out && rxd_oe_n_out && !irq_out)
      else $error("outputs not at rest after reset");
   chk_rdata_idle: assert property (
      !$past(rd_in) |-> rdata_out == BYTE_ZERO)
      else $error("read data outside the answer cycle");
   chk_unmapped_read: assert property (
      rd_in && addr_in == 8'h00 |=> rdata_out == BYTE_ZERO)
      else $error("unmapped read not zero");
   chk_irq_masked: assert property (
      mzero_reg && $past(mzero_reg) && $past(mzero_reg, 2) |-> !irq_out)
      else $error("interrupt with all events masked");
   chk_irq_cause: assert property (
      $rose(irq_out) |-> !mzero_reg)
      else $error("interrupt rose under a zero mask");
   chk_async_pins: assert property (
      mode_reg != 2'h0 && $past(mode_reg) != 2'h0
         && $past(mode_reg, 2) != 2'h0 |-> sclk_out && rxd_oe_n_out)
      else $error("shift clock or data drive outside mode 0");
   chk_tx_start: assert property (
      mode_reg[1] && wr_in && addr_in == SER_DATA_OFS |-> ##[1:130] !txd_out)
      else $error("no start bit after data write");
   chk_start_length: assert property (
      mode_reg[1] && $fell(txd_out) |-> (!txd_out) [*8])
      else $error("async bit shorter than expected");
endmodule
bind ssp_core ssp_core_monitor mon (.mclk_in, .rst_in, .addr_in, .wdata_in,
   .wr_in, .rd_in, .timer_ovf_in, .rxd_in, .rdata_out, .txd_out, .sclk_out,
   .rxd_oe_n_out, .irq_out);

// ---- ssp_peer.sv ----
// Far-end serial station: frame catcher and frame sender
`timescale 1ns/1ns
module ssp_peer
(
   input wire logic mclk_in,
   input wire logic line_in,
   output logic line_out
);
   // ------------------------------------------------------------
   // Receiver samples mid bit, sender holds each bit 64 clocks
   // ------------------------------------------------------------
   localparam int BIT_CLKS = 64;
   logic [8:0] got_reg;
   int n_got = 0;
   initial line_out = 1'b1;
   always begin
      @(negedge line_in);
      repeat (BIT_CLKS / 2) @(posedge mclk_in);
      for (int i = 0; i < 9; i++) begin
         repeat (BIT_CLKS) @(posedge mclk_in);
         got_reg[i] = line_in;
      end
      repeat (BIT_CLKS) @(posedge mclk_in);
      n_got = n_got + 1;
   end
   task automatic send(input logic [7:0] d, input logic b9,
      input logic nine, input logic stop);
      logic [10:0] f;
      f = {stop, b9, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         if (i != 9 || nine) begin
            line_out <= f[i];
            repeat (BIT_CLKS) @(posedge mclk_in);
         end
      end
      line_out <= 1'b1;
   endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the second serial port
`timescale 1ns/1ns
module tb_top
   import ssp_pkg::*;
;
   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] msk;
      logic [7:0] dat;
      logic b9;
      logic stp;
      logic ri;
   } ssp_row_t;
   localparam ssp_row_t ROWS [8] = '{
      '{8'hB0, 8'hF0, 8'h3C, 1'b0, 1'b1, 1'b0},
      '{8'hB0, 8'hF0, 8'h35, 1'b1, 1'b1, 1'b1},
      '{8'hB0, 8'hF0, 8'h45, 1'b1, 1'b1, 1'b0},
      '{8'hB0, 8'h00, 8'h99, 1'b1, 1'b1, 1'b1},
      '{8'h80, 8'h00, 8'h99, 1'b1, 1'b1, 1'b0},
      '{8'h70, 8'h00, 8'h5E, 1'b0, 1'b0, 1'b0},
      '{8'h50, 8'h00, 8'hE1, 1'b0, 1'b1, 1'b1},
      '{8'hD0, 8'h00, 8'h2B, 1'b0, 1'b1, 1'b1}};
   logic mclk_in, rst_in, wr_in, rd_in, timer_ovf_in, rxd_in, peer_rx;
   logic txd_out, sclk_out, rxd_oe_n_out, irq_out, sc_q;
   logic [7:0] addr_in, wdata_in, rdata_out, v;
   int n_fail = 0, cmp_count = 0, cyc = 0, tl = 0, t0 = 0, nb = 0;
   ssp_core DUT (.mclk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
      .timer_ovf_in, .rxd_in, .rdata_out, .txd_out, .sclk_out,
      .rxd_oe_n_out, .irq_out);
   ssp_peer peer (.mclk_in, .line_in(txd_out), .line_out(peer_rx));
   // Shared data pin: the port drives it during mode 0 transmit
   assign rxd_in = (rxd_oe_n_out !== 1'b0) ? peer_rx : txd_out;
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   // ------------------------------------------------------------
   // Timer ticks, shift clock edge log, run limit
   // ------------------------------------------------------------
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      timer_ovf_in <= (cyc % 4 == 3);
      sc_q <= sclk_out;
      if (sc_q === 1'b1 && sclk_out === 1'b0) begin
         t0 <= (cyc - tl > 50) ? cyc : t0;
         nb <= (cyc - tl > 50) ? 1 : nb + 1;
         tl <= cyc;
      end
      if (cyc == 40000) begin
         n_fail++;
         end_of_test();
      end
   end
   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
      @(posedge mclk_in);
   endtask
   task automatic rd(input logic [7:0] a);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      @(negedge mclk_in);
      v = rdata_out;
      @(posedge mclk_in);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   task automatic tx_run(input logic [7:0] c, input logic [7:0] d);
      int k;
      k = peer.n_got;
      wr(SER_CTRL_OFS, c);
      wr(SER_DATA_OFS, d);
      rd(TX_STATUS_OFS);
      cmp8({7'h0, v[0]}, 8'h01);
      repeat (2000) if (peer.n_got == k) idle(1);
      // Let the stop bit finish before the port is touched again
      idle(48);
      cmp8(peer.got_reg[7:0], d);
      cmp8({7'h0, peer.got_reg[8]}, {7'h0, c[CTL_TB8]});
      rd(SER_CTRL_OFS);
      cmp8({7'h0, v[CTL_TI]}, 8'h01);
      rd(TX_STATUS_OFS);
      cmp8({7'h0, v[0]}, 8'h00);
      $display("tx test done");
   endtask
   task automatic m0_run(input logic [7:0] c, input int div);
      wr(SER_CTRL_OFS, c);
      wr(SER_DATA_OFS, 8'h96);
      idle(200);
      cmp8(8'(nb), 8'h08);
      cmp8(8'(tl - t0), 8'(7 * div));
      rd(SER_CTRL_OFS);
      cmp8({7'h0, v[CTL_TI]}, 8'h01);
      $display("mode 0 test done");
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      rst_in <= 1'b1;
      {wr_in, rd_in, addr_in, wdata_in} <= '0;
      repeat (12) @(posedge mclk_in);
      rst_in <= 1'b0;
      wr(STATION_ADDR_OFS, 8'h3C);
      wr(IRQ_MASK_OFS, 8'h07);
      foreach (ROWS[i]) begin
         wr(SER_CTRL_OFS, ROWS[i].ctl);
         wr(ADDR_MASK_OFS, ROWS[i].msk);
         rd(ADDR_MASK_OFS);
         cmp8(v, ROWS[i].msk);
         peer.send(ROWS[i].dat, ROWS[i].b9, ROWS[i].ctl[7], ROWS[i].stp);
         idle(40);
         rd(SER_CTRL_OFS);
         cmp8({7'h0, v[CTL_RI]}, {7'h0, ROWS[i].ri});
         if (ROWS[i].ri) begin
            cmp8({7'h0, v[CTL_RB8]},
               {7'h0, ROWS[i].ctl[7] ? ROWS[i].b9 : ROWS[i].stp});
            rd(SER_DATA_OFS);
            cmp8(v, ROWS[i].dat);
         end
         $display("rx row %0d done", i);
      end
      tx_run(8'h88, 8'h5A);
      tx_run(8'hC0, 8'hA5);
      wr(IRQ_MASK_OFS, 8'h00);
      idle(3);
      cmp8({7'h0, irq_out}, 8'h00);
      wr(IRQ_MASK_OFS, 8'h01);
      idle(3);
      cmp8({7'h0, irq_out}, 8'h01);
      wr(IRQ_STATUS_OFS, 8'h07);
      idle(3);
      cmp8({7'h0, irq_out}, 8'h00);
      rd(IRQ_STATUS_OFS);
      cmp8(v, BYTE_ZERO);
      wr(SER_CTRL_OFS, 8'h50);
      wr(POWER_CTRL_OFS, 8'h40);
      peer.send(8'h11, 1'b0, 1'b0, 1'b0);
      idle(40);
      rd(SER_CTRL_OFS);
      cmp8({7'h0, v[CTL_SM0]}, 8'h01);
      wr(SER_CTRL_OFS, 8'h50);
      rd(SER_CTRL_OFS);
      cmp8({7'h0, v[CTL_SM0]}, 8'h00);
      wr(POWER_CTRL_OFS, 8'h00);
      $display("framing error test done");
      m0_run(8'h00, 12);
      m0_run(8'h20, 4);
      wr(SER_CTRL_OFS, 8'h10);
      idle(120);
      rd(SER_CTRL_OFS);
      cmp8({7'h0, v[CTL_RI]}, 8'h01);
      rd(SER_DATA_OFS);
      cmp8(v, 8'hFF);
      rd(8'h00);
      cmp8(v, BYTE_ZERO);
      $display("mode 0 receive test done");
      rst_in <= 1'b1;
      idle(3);
      rst_in <= 1'b0;
      rd(SER_CTRL_OFS);
      cmp8(v, CTRL_RST);
      rd(SER_DATA_OFS);
      cmp8(v, BYTE_ZERO);
      $display("reset test done");
      end_of_test();
   end
endmodule
